// ### rtl/rxcw_pkg.sv
// Package for the receive subaddress control word block.
// Assumes a single sys_clk domain; used by rxcw_top and rxcw_busy_gate.
package rxcw_pkg;
  // --------------------------------------------------------------------
  // Word layout
  // --------------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int BIT_IXZ = 15;
  localparam int BIT_IWA = 14;
  localparam int BIT_IBR = 13;
  localparam int BIT_BUSY = 12;
  localparam int BIT_ACC = 11;
  localparam int BIT_NBS = 10;
  localparam int BIT_BCS = 9;
  localparam int BIT_PPA = 8;
  localparam int BIT_PINGPONG_ENABLE = 2;
  localparam int BIT_STOP = 3;
  // Host write and soft reset masks
  localparam logic [15:0] MASK_ANYTIME = 16'hf008;
  localparam logic [15:0] MASK_IDLE = 16'h00f7;
  localparam logic [15:0] MASK_DEVICE = 16'h0f00;
  localparam logic [15:0] MASK_SOFT_CLR = 16'h0e00;
  // --------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------
  localparam logic [4:0] SA_MIN = 5'h01;
  localparam logic [4:0] SA_MAX = 5'h1e;
  // Interrupt cause encoding on irq_cause
  localparam logic [2:0] CAUSE_IXZ = 3'h4;
  localparam logic [2:0] CAUSE_IWA = 3'h2;
  localparam logic [2:0] CAUSE_IBR = 3'h1;
endpackage

// ### rtl/rxcw_busy_gate.sv
// Busy gate: decides whether a command applies and whether data may be stored.
// Assumes synchronous command inputs from the terminal protocol logic.
`timescale 1ns/1ps
`default_nettype none
module rxcw_busy_gate (
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_tr,
  input wire logic [4:0] cmd_sa,
  // Word
  input wire logic force_busy,
  // Results
  output logic applies,
  output logic busy_reply,
  output logic store_ok
);
  wire sa_ok = (cmd_sa >= rxcw_pkg::SA_MIN) && (cmd_sa <= rxcw_pkg::SA_MAX);
  assign applies = cmd_valid && !cmd_tr && sa_ok; // RQ1
  assign busy_reply = applies && force_busy; // RQ13
  assign store_ok = applies && !force_busy; // RQ13
endmodule
`default_nettype wire

// ### rtl/rxcw_top.sv
// Receive subaddress descriptor control word with host access and device updates.
// Assumes host access is one-cycle strobes; message completion comes from the protocol core.
//
// Overview of operation
// RQ1 - Word applies to receive commands, subaddress 1-30
// RQ2 - Host initialises word before enabling execution
// RQ3 - Bits 8-11 are device owned, never host
// RQ4 - Bits 0-2,4-7 writable only when stopped
// RQ5 - Master reset clears whole word to zero
// RQ6 - Soft reset clears accessed, pointer, broadcast flags
// RQ7 - Any host read clears the accessed flag; a completion in the same cycle keeps it set
// RQ8 - Host writes ping-pong words only while enabled
// RQ9 - Index-zero interrupt when enabled and index reaches zero
// RQ10 - Enabled interrupts pulse pending, pin and log
// RQ11 - Access interrupt on any valid receive command
// RQ12 - Broadcast interrupt on valid broadcast command
// RQ13 - Force busy: busy reply, no store, pointer held
// RQ14 - Accessed flag set on message completion
// RQ15 - Pointer selects buffer A or B
// RQ16 - Pointer toggles after error-free ping-pong message
// RQ17 - Host should set toggle-on-success option
// RQ18 - Broadcast flag set on valid broadcast command
// RQ19 - Blocked host bits unchanged, others still written
`timescale 1ns/1ps
`default_nettype none
module rxcw_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Resets and global configuration
  input wire logic master_reset,
  input wire logic soft_reset,
  input wire logic terminal1_run,
  input wire logic terminal1_enable,
  input wire logic broadcast_disable,
  input wire logic toggle_on_success_only,
  input wire logic glb_ixz_en,
  input wire logic glb_iwa_en,
  input wire logic glb_ibr_en,
  // Host access
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  // Command from protocol core
  input wire logic cmd_valid,
  input wire logic cmd_tr,
  input wire logic cmd_broadcast_seen_flag,
  input wire logic [4:0] cmd_sa,
  input wire logic msg_done,
  input wire logic msg_ok,
  input wire logic index_hit_zero,
  // Results to protocol core and interrupt logic
  output logic busy_status,
  output logic store_enable,
  output logic buffer_b_select,
  output logic irq_pending,
  output logic [2:0] irq_cause
);
  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    RXCW_IDLE = 3'b001,
    RXCW_ACTIVE = 3'b010,
    RXCW_FINISH = 3'b100
  } rxcw_state_t;

  rxcw_state_t state, next_state;
  logic [15:0] word, next_word;
  logic broadcast_seen_flag_msg, next_broadcast_seen_flag_msg;
  logic busy_msg, next_busy_msg;
  logic applies, busy_reply, store_ok;

  // A broadcast command is not valid while broadcast is disabled, so it never applies
  wire cmd_take = cmd_valid && !(cmd_broadcast_seen_flag && broadcast_disable); // RQ12

  rxcw_busy_gate u_gate (
    .cmd_valid(cmd_take),
    .cmd_tr(cmd_tr),
    .cmd_sa(cmd_sa),
    .force_busy(word[rxcw_pkg::BIT_BUSY]),
    .applies(applies),
    .busy_reply(busy_reply),
    .store_ok(store_ok)
  );

  // --------------------------------------------------------------------
  // Host write mask
  // --------------------------------------------------------------------
  // Locked bits fall out of the mask, so the rest of the word still updates
  wire [15:0] wr_mask = rxcw_pkg::MASK_ANYTIME | (terminal1_run ? 16'h0000 : rxcw_pkg::MASK_IDLE); // RQ4 RQ19
  wire [15:0] host_mask = wr_mask & ~rxcw_pkg::MASK_DEVICE; // RQ3
  wire [15:0] after_wr = host_wr ? ((word & ~host_mask) | (host_wdata & host_mask)) : word;

  // --------------------------------------------------------------------
  // Completion events
  // --------------------------------------------------------------------
  wire in_msg = (state == RXCW_ACTIVE);
  wire done_now = in_msg && msg_done;
  // Broadcast is only valid when not disabled; RT31 commands are otherwise ignored
  wire bc_ok = broadcast_seen_flag_msg && !broadcast_disable;
  wire ppong_on = word[rxcw_pkg::BIT_PINGPONG_ENABLE] && word[rxcw_pkg::BIT_PPA];
  wire tog_ok = msg_ok || !toggle_on_success_only;
  wire do_toggle = done_now && ppong_on && !busy_msg && tog_ok; // RQ16
  wire ev_ixz = done_now && index_hit_zero && word[rxcw_pkg::BIT_IXZ] && glb_ixz_en; // RQ9
  wire ev_iwa = done_now && word[rxcw_pkg::BIT_IWA] && glb_iwa_en; // RQ11
  wire ev_ibr = done_now && bc_ok && word[rxcw_pkg::BIT_IBR] && glb_ibr_en; // RQ12
  wire [2:0] next_cause = {ev_ixz, ev_iwa, ev_ibr};
  // Ack follows enable only while the terminal is armed and not stopped
  wire ppa_next = word[rxcw_pkg::BIT_PINGPONG_ENABLE] && !word[rxcw_pkg::BIT_STOP] && terminal1_enable && terminal1_run;

  // --------------------------------------------------------------------
  // Next state and next word
  // --------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_broadcast_seen_flag_msg = broadcast_seen_flag_msg;
    next_busy_msg = busy_msg;
    case (state)
      RXCW_IDLE: begin
        if (applies) begin // RQ1
          next_state = RXCW_ACTIVE;
          next_broadcast_seen_flag_msg = cmd_broadcast_seen_flag;
          next_busy_msg = busy_reply;
        end
      end
      RXCW_ACTIVE: begin
        if (msg_done) begin
          next_state = RXCW_FINISH;
        end
      end
      RXCW_FINISH: begin
        next_state = RXCW_IDLE;
      end
      default: begin
        next_state = RXCW_IDLE;
      end
    endcase
  end

  always_comb begin
    next_word = after_wr;
    if (terminal1_run) begin
      next_word[rxcw_pkg::BIT_PPA] = ppa_next;
    end
    // Read clear comes first so that a completion in the same cycle wins
    if (host_rd) begin
      next_word[rxcw_pkg::BIT_ACC] = 1'b0; // RQ7
    end
    if (done_now) begin
      next_word[rxcw_pkg::BIT_ACC] = 1'b1; // RQ14
    end
    if (in_msg && bc_ok) begin
      next_word[rxcw_pkg::BIT_BCS] = 1'b1; // RQ18
    end
    if (do_toggle) begin
      next_word[rxcw_pkg::BIT_NBS] = ~word[rxcw_pkg::BIT_NBS]; // RQ16
    end
    if (soft_reset) begin
      next_word = next_word & ~rxcw_pkg::MASK_SOFT_CLR; // RQ6
    end
    if (master_reset) begin
      next_word = rxcw_pkg::WORD_RESET; // RQ5
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= RXCW_IDLE;
      broadcast_seen_flag_msg <= 1'b0;
      busy_msg <= 1'b0;
    end else begin
      state <= master_reset ? RXCW_IDLE : next_state;
      broadcast_seen_flag_msg <= next_broadcast_seen_flag_msg;
      busy_msg <= next_busy_msg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      word <= rxcw_pkg::WORD_RESET; // RQ5
    end else begin
      word <= next_word;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata <= 16'h0000;
      busy_status <= 1'b0;
      store_enable <= 1'b0;
      buffer_b_select <= 1'b0;
      irq_pending <= 1'b0;
      irq_cause <= 3'h0;
    end else begin
      host_rdata <= word;
      busy_status <= busy_reply | (in_msg && busy_msg); // RQ13
      store_enable <= store_ok | (in_msg && !busy_msg); // RQ13
      buffer_b_select <= next_word[rxcw_pkg::BIT_NBS]; // RQ15
      irq_pending <= |next_cause; // RQ10
      irq_cause <= next_cause; // RQ10
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  AST_MR_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b) master_reset |=> word == 16'h0000) // RQ5
    else $error("Master reset did not clear word");
  AST_SR_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (soft_reset && !master_reset && !host_wr && !terminal1_run) |=> word[15:12] == $past(word[15:12])) // RQ6
    else $error("Soft reset changed kept bits");
  AST_SR_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    soft_reset |=> word[11:9] == 3'h0) // RQ6
    else $error("Soft reset left flags set");
  AST_RD_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (host_rd && !done_now) |=> !word[rxcw_pkg::BIT_ACC]) // RQ7
    else $error("Read did not clear accessed flag");
  AST_ACC_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (done_now && !soft_reset && !master_reset) |=> word[rxcw_pkg::BIT_ACC]) // RQ14
    else $error("Accessed flag not set on completion");
  AST_HOST_NO_DEV: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (host_wr && !terminal1_run && !in_msg && !soft_reset && !master_reset && !host_rd)
      |=> word[11:8] == $past(word[11:8])) // RQ3
    else $error("Host write changed device bits");
  AST_LOCK_RUN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (host_wr && terminal1_run && !master_reset) |=> (word & 16'h00f7) == ($past(word) & 16'h00f7)) // RQ4
    else $error("Locked bits written while running");
  AST_ANYTIME_WR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (host_wr && !master_reset) |=> (word & 16'hf008) == ($past(host_wdata) & 16'hf008)) // RQ19
    else $error("Anytime bits not written");
  AST_BUSY_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (done_now && busy_msg && !soft_reset && !master_reset) |=> $stable(word[rxcw_pkg::BIT_NBS])) // RQ13
    else $error("Pointer toggled on busy message");
  AST_IWA_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ev_iwa |=> irq_pending && irq_cause[1] ##1 !irq_pending) // RQ11
    else $error("Access interrupt not pulsed");
  AST_APPLY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == RXCW_IDLE && cmd_valid && (cmd_tr || cmd_sa == 5'h00 || cmd_sa == 5'h1f)) |=> state == RXCW_IDLE) // RQ1
    else $error("Word applied to non-receive command");

  // --------------------------------------------------------------------
  // Device-side checks, plus the host idle-write and state checks
  // --------------------------------------------------------------------
  AST_PPA_FOLLOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (terminal1_run && !master_reset)
      |=> word[rxcw_pkg::BIT_PPA] == $past(ppa_next)) // RQ3
    else $error("Ack bit did not follow ping-pong state");
  AST_BCS_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (in_msg && bc_ok && !soft_reset && !master_reset)
      |=> word[rxcw_pkg::BIT_BCS]) // RQ18
    else $error("Broadcast flag not set");
  AST_BROADCAST_SEEN_FLAG_OFF: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == RXCW_IDLE && cmd_valid && cmd_broadcast_seen_flag && broadcast_disable)
      |=> state == RXCW_IDLE) // RQ12
    else $error("Disabled broadcast command applied");
  AST_TOGGLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (do_toggle && !soft_reset && !master_reset)
      |=> word[rxcw_pkg::BIT_NBS] != $past(word[rxcw_pkg::BIT_NBS])) // RQ16
    else $error("Pointer did not toggle");
  AST_BUF_SEL: assert property (@(posedge sys_clk) disable iff (!rst_b)
    buffer_b_select == word[rxcw_pkg::BIT_NBS]) // RQ15
    else $error("Buffer select differs from pointer");
  AST_BUSY_OUT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == RXCW_IDLE && busy_reply && !master_reset)
      |=> busy_status && !store_enable) // RQ13
    else $error("Busy command not answered busy");
  AST_IXZ_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ev_ixz
      |=> irq_pending && irq_cause[2]) // RQ9
    else $error("Index-zero interrupt not raised");
  AST_IBR_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ev_ibr
      |=> irq_pending && irq_cause[0]) // RQ12
    else $error("Broadcast interrupt not raised");
  AST_NO_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(|next_cause)
      |=> !irq_pending) // RQ10
    else $error("Interrupt raised without cause");
  AST_IDLE_WR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (host_wr && !terminal1_run && !master_reset && !soft_reset)
      |=> (word & rxcw_pkg::MASK_IDLE) == ($past(host_wdata) & rxcw_pkg::MASK_IDLE)) // RQ4
    else $error("Idle bits not written while stopped");
  AST_ONE_HOT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $onehot(state)) // RQ1
    else $error("State not one-hot");
endmodule
`default_nettype wire

// ### tb/rxcw_core_model.sv
// Model of the protocol core that hands commands to the control word.
// Assumes rxcw_top samples these lines on rising edges of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module rxcw_core_model (
  // Clock
  input wire logic sys_clk,
  // Command and completion
  output logic cmd_valid,
  output logic cmd_tr,
  output logic cmd_broadcast_seen_flag,
  output logic [4:0] cmd_sa,
  output logic msg_done,
  output logic msg_ok,
  output logic index_hit_zero
);
  initial begin
    {cmd_valid, cmd_tr, cmd_broadcast_seen_flag, cmd_sa, msg_done, msg_ok, index_hit_zero} = '0;
  end
  task automatic send(input logic tr, input logic bc, input logic [4:0] sa);
    @(posedge sys_clk);
    {cmd_valid, cmd_tr, cmd_broadcast_seen_flag, cmd_sa} <= {1'b1, tr, bc, sa};
    @(posedge sys_clk);
    // Released lines flip so a stale value never passes as valid
    {cmd_valid, cmd_tr, cmd_broadcast_seen_flag, cmd_sa} <= {1'b0, ~tr, ~bc, ~sa};
  endtask
  // Gap sets how slowly the message body runs before completion
  task automatic finish(input logic ok, input logic ixz, input int gap);
    repeat (gap) @(posedge sys_clk);
    {msg_done, msg_ok, index_hit_zero} <= {1'b1, ok, ixz};
    @(posedge sys_clk);
    {msg_done, msg_ok, index_hit_zero} <= {1'b0, ~ok, ~ixz};
    repeat (2) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ### tb/rxcw_top_test.sv
// Self-checking bench for the receive control word block.
// Assumes rxcw_top and rxcw_core_model; reads show the word one edge late.
`timescale 1ns/1ps
`default_nettype none
module rxcw_top_test;
  logic sys_clk, rst_b, master_reset, soft_reset, terminal1_run, terminal1_enable, rd_d1;
  logic broadcast_disable, toggle_on_success_only, glb_ixz_en, glb_iwa_en, glb_ibr_en;
  logic host_wr, host_rd, busy_status, store_enable, buffer_b_select, irq_pending;
  logic cmd_valid, cmd_tr, cmd_broadcast_seen_flag, msg_done, msg_ok, index_hit_zero;
  logic [4:0] cmd_sa;
  logic [2:0] irq_cause;
  logic [15:0] host_wdata, host_rdata, w;
  logic [15:0] rd_q[$];
  logic [2:0] irq_q[$];
  logic [6:0] bad[4] = '{7'h00, 7'h1f, 7'h41, 7'h3e};
  int n_fail, comparisons;
  rxcw_top i_rxcw_top (.*);
  rxcw_core_model i_rxcw_core_model (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // --------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) rd_d1 <= host_rd;
  // Sampled mid-cycle, after the registered outputs have settled
  always @(negedge sys_clk) begin
    if (rd_d1 === 1'b1) check("word", rd_q.pop_front(), host_rdata);
    if (irq_pending === 1'b1) begin
      if (irq_q.size() == 0) check("irq_unexpected", 16'h0, 16'h1);
      else check("irq_cause", {13'h0, irq_q.pop_front()}, {13'h0, irq_cause});
    end
  end
  // --------------------------------------------------------------
  // Drivers
  // --------------------------------------------------------------
  task automatic wr(input logic [15:0] d);
    logic [15:0] m;
    @(posedge sys_clk);
    // Mask taken after the edge so a run change made just before the call has landed
    m = terminal1_run ? rxcw_pkg::MASK_ANYTIME : (rxcw_pkg::MASK_ANYTIME | rxcw_pkg::MASK_IDLE);
    w = (w & ~m) | (d & m);
    host_wr <= 1'b1;
    host_wdata <= d;
    @(posedge sys_clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] e);
    @(posedge sys_clk);
    host_rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge sys_clk);
    host_rd <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic msg(input logic bc, input logic [4:0] sa, input logic ok, input logic [2:0] c, input int gap);
    i_rxcw_core_model.send(1'b0, bc, sa);
    #1;
    check("busy", {15'h0, w[12]}, {15'h0, busy_status});
    check("store", {15'h0, ~w[12]}, {15'h0, store_enable});
    if (c != 3'h0) irq_q.push_back(c);
    i_rxcw_core_model.finish(ok, c[2], gap);
    w[11] = 1'b1;
    if (bc) w[9] = 1'b1;
    if (w[8] && !w[12] && ok) w[10] = ~w[10];
    check("next_buf", {15'h0, w[10]}, {15'h0, buffer_b_select});
    rd(w);
  endtask
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    {rst_b, master_reset, soft_reset, terminal1_run, terminal1_enable, rd_d1} = '0;
    {broadcast_disable, toggle_on_success_only, glb_ixz_en, glb_iwa_en, glb_ibr_en} = '0;
    {host_wr, host_rd, host_wdata} = '0;
    n_fail = 0;
    comparisons = 0;
    w = rxcw_pkg::WORD_RESET;
    void'($urandom(32'h64f5));
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(w);
    wr(16'($urandom()));
    rd(w);
    terminal1_run <= 1'b1;
    wr(16'($urandom()));
    rd(w);
    terminal1_run <= 1'b0;
    wr(16'he004);
    {terminal1_enable, toggle_on_success_only, glb_ixz_en, glb_iwa_en, glb_ibr_en} <= '1;
    terminal1_run <= 1'b1;
    repeat (3) @(posedge sys_clk);
    w[8] = 1'b1;
    rd(w);
    msg(1'b0, 5'($urandom_range(30, 1)), 1'b1, 3'h6, 1);
    w[11] = 1'b0;
    rd(w);
    msg(1'b1, 5'h1e, 1'b1, 3'h3, 4);
    msg(1'b0, 5'h01, 1'b0, 3'h2, 2);
    @(posedge sys_clk);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    w = w & ~rxcw_pkg::MASK_SOFT_CLR;
    rd(w);
    broadcast_disable <= 1'b1;
    foreach (bad[i]) begin
      i_rxcw_core_model.send(bad[i][6], bad[i][5], bad[i][4:0]);
      i_rxcw_core_model.finish(1'b1, 1'b1, 1);
    end
    rd(w);
    wr(w | 16'h1000);
    msg(1'b0, 5'h02, 1'b1, 3'h2, 1);
    {glb_ixz_en, glb_iwa_en, glb_ibr_en} <= '0;
    msg(1'b0, 5'h03, 1'b1, 3'h0, 1);
    @(posedge sys_clk);
    master_reset <= 1'b1;
    @(posedge sys_clk);
    master_reset <= 1'b0;
    w = rxcw_pkg::WORD_RESET;
    rd(w);
    check("irq_left", 16'h0, 16'(irq_q.size()));
    complete_run();
  end
  initial begin
    #20000;
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
